//--- logic/frc_flash_rewrite_control.sv
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module frc_flash_rewrite_control
#(
  parameter bit HAS_DATA_FLASH = 1'b1
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire frc_pkg::frc_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins from outside
  input wire logic [1:0] modePins,
  input wire logic idCheckPass,
  input wire logic romProtect,
  // flash array side
  output frc_pkg::frc_array_req_t arrayReq,
  input wire logic arrayBusy,
  // status out
  output logic fetchFromFlashOk,
  output logic bootSelect
);
  import frc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] syncA;
  logic [3:0] syncB;
  wire [3:0] pinsIn = {romProtect, idCheckPass, modePins};
  // nothing but the second stage reads the first, and only the second feeds logic
  always_ff @(posedge ref_clk)
  begin
    syncA <= pinsIn;
    syncB <= syncA;
  end
  wire frc_mode_t mode = frc_mode_t'(syncB[1:0]);
  wire idOk = syncB[2];
  wire protectOn = syncB[3];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] flash_control_reg_a;
  logic [7:0] flash_control_reg_b;
  logic [7:0] cmdData;
  logic [2:0] cmdBlock;
  frc_cmd_t lastCmd;
  frc_state_t state;
  logic [7:0] opCount;
  logic lockError;
  logic cmdError;

  wire global_lock_release = flash_control_reg_a[FRC_GLOBAL_RELEASE_BIT];
  wire ram_exec_rewrite_submode = flash_control_reg_a[FRC_RAM_SUBMODE_BIT];
  wire flash_exec_rewrite_submode = ~ram_exec_rewrite_submode;
  wire block0_lock = flash_control_reg_b[FRC_BLOCK0_LOCK_BIT];
  wire block1_lock = flash_control_reg_b[FRC_BLOCK1_LOCK_BIT];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire access = apbReq.psel & apbReq.penable;
  wire wrEn = access & apbReq.pwrite;
  wire hitA = apbReq.paddr == FRC_CTRL_A_OFS;
  wire hitB = apbReq.paddr == FRC_CTRL_B_OFS;
  wire hitCmd = apbReq.paddr == FRC_CMD_OFS;
  wire hitStat = apbReq.paddr == FRC_STAT_OFS;
  wire mapped = hitA | hitB | hitCmd | hitStat;
  wire frc_cmd_t cmdCode = frc_cmd_t'(apbReq.pwdata[2:0]);
  wire cmdWrite = wrEn & hitCmd;
  wire [2:0] reqBlock = apbReq.pwdata[10:8];

  // ----------------------------------------
  // lock evaluation
  // ----------------------------------------
  wire [FRC_BLOCKS-1:0] blockOk;
  genvar gi;
  generate
    for (gi = 0; gi < FRC_BLOCKS; gi++)
    begin : gen_lock
      if (gi == 0)
      begin : g0
        assign blockOk[gi] = global_lock_release & ~block0_lock;
      end
      else if (gi == 1)
      begin : g1
        assign blockOk[gi] = global_lock_release & ~block1_lock;
      end
      else if (gi < 4)
      begin : g23
        assign blockOk[gi] = global_lock_release;
      end
      else
      begin : gdata
        // data blocks A and B exist only on the larger variant
        assign blockOk[gi] = global_lock_release & HAS_DATA_FLASH;
      end
    end
  endgenerate

  // block numbers past the last block count as locked instead of indexing off the vector
  wire inRange = reqBlock < 3'(FRC_BLOCKS);
  wire blockHit = inRange ? blockOk[reqBlock] : 1'b0;
  // each mode has its own gate; serial and parallel bypass the cpu lock bits
  wire cpuOk = (mode == FRC_MODE_CPU) & blockHit;
  wire serialOk = (mode == FRC_MODE_SERIAL) & idOk;
  wire parallelOk = (mode == FRC_MODE_PARALLEL) & ~protectOn;
  // the fourth pin code is no mode at all and denies every rewrite
  wire modeOk = cpuOk | serialOk | parallelOk;
  wire isWriteCmd = (cmdCode == FRC_CMD_PROGRAM) | (cmdCode == FRC_CMD_BLOCK_ERASE);
  wire knownCmd = isWriteCmd | (cmdCode == FRC_CMD_READ_ARRAY) |
                  (cmdCode == FRC_CMD_READ_STATUS) | (cmdCode == FRC_CMD_CLEAR_STATUS);
  wire cmdAccepted = (mode != FRC_MODE_SERIAL) | idOk;
  wire startOp = cmdWrite & isWriteCmd & cmdAccepted & (state == FRC_ST_IDLE);
  wire launch = startOp & inRange & modeOk;
  wire denied = startOp & ~(inRange & modeOk);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flash_control_reg_a <= FRC_CTRL_A_RST;
      flash_control_reg_b <= FRC_CTRL_B_RST;
    end
    else
    begin
      // only the low byte is implemented; upper write data is dropped
      if (wrEn & hitA)
      begin
        flash_control_reg_a <= apbReq.pwdata[7:0];
      end
      if (wrEn & hitB)
      begin
        flash_control_reg_b <= apbReq.pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  frc_state_t next_state;
  // the array may outlast the minimum time, so busy waits for both
  wire opDone = (opCount == 8'h00) & ~arrayBusy;
  always_comb
  begin
    next_state = state;
    case (state)
      FRC_ST_IDLE:
      begin
        if (launch)
          next_state = FRC_ST_BUSY;
      end
      FRC_ST_BUSY:
      begin
        if (opDone)
          next_state = FRC_ST_DONE;
      end
      // done lasts one cycle before the sequencer takes commands again
      FRC_ST_DONE:
      begin
        next_state = FRC_ST_IDLE;
      end
      default:
      begin
        next_state = FRC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state <= FRC_ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      opCount <= 8'h00;
      cmdBlock <= 3'h0;
      cmdData <= 8'h00;
      lastCmd <= FRC_CMD_READ_ARRAY;
    end
    else
    begin
      if (launch)
      begin
        opCount <= 8'(FRC_OP_CYC);
        cmdBlock <= reqBlock;
        cmdData <= apbReq.pwdata[23:16];
        lastCmd <= cmdCode;
      end
      else if (opCount != 8'h00)
        opCount <= opCount - 8'h01;
    end
  end

  // ----------------------------------------
  // error flags: a new error wins over a clear
  // ----------------------------------------
  wire clearErr = cmdWrite & (cmdCode == FRC_CMD_CLEAR_STATUS);
  wire badCmd = cmdWrite & ~knownCmd;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lockError <= 1'b0;
      cmdError <= 1'b0;
    end
    else
    begin
      lockError <= denied | (lockError & ~clearErr);
      cmdError <= badCmd | (cmdError & ~clearErr);
    end
  end

  // ----------------------------------------
  // array request, one pulse per accepted command
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      arrayReq <= '0;
    end
    else
    begin
      arrayReq.valid <= (state == FRC_ST_IDLE) & (next_state == FRC_ST_BUSY);
      // boot area replaces the user area at the same addresses in boot mode
      arrayReq.bootArea <= (mode == FRC_MODE_SERIAL);
      // command fields stay put after the pulse so the array may read them late
      if (launch)
      begin
        arrayReq.erase <= (cmdCode == FRC_CMD_BLOCK_ERASE);
        arrayReq.block <= reqBlock;
        arrayReq.data <= apbReq.pwdata[23:16];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bootSelect <= 1'b0;
      fetchFromFlashOk <= 1'b0;
    end
    else
    begin
      bootSelect <= (mode == FRC_MODE_SERIAL);
      // in ram sub-mode instruction fetch from flash is cut during a rewrite
      fetchFromFlashOk <= flash_exec_rewrite_submode | (state == FRC_ST_IDLE);
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  wire [31:0] statWord = {16'h0000, 3'h0, cmdBlock, 1'b0, lastCmd, cmdError, lockError,
                          state, mode};
  wire [31:0] readMux = hitA ? {24'h00_0000, flash_control_reg_a} :
                        hitB ? {24'h00_0000, flash_control_reg_b} :
                        hitStat ? statWord : 32'h0000_0000;
  // zero wait state slave: read data is captured in the setup cycle so it stands in the access
  wire setupRead = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (setupRead)
      prdata <= readMux;
  end

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  wire unusedData = ^cmdData;

endmodule

//--- logic/frc_pkg.sv
package frc_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] FRC_CTRL_A_OFS = 8'h00;
  localparam logic [7:0] FRC_CTRL_B_OFS = 8'h04;
  localparam logic [7:0] FRC_CMD_OFS = 8'h08;
  localparam logic [7:0] FRC_STAT_OFS = 8'h0C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FRC_GLOBAL_RELEASE_BIT = 2;
  localparam int FRC_RAM_SUBMODE_BIT = 1;
  localparam int FRC_BLOCK0_LOCK_BIT = 5;
  localparam int FRC_BLOCK1_LOCK_BIT = 6;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] FRC_CTRL_A_RST = 8'h00;
  localparam logic [7:0] FRC_CTRL_B_RST = 8'h60;

  // ----------------------------------------
  // geometry and timing
  // ----------------------------------------
  localparam int FRC_BLOCKS = 6;
  localparam int FRC_DATA_BLOCK_BYTES = 1024;
  localparam int FRC_CLK_HZ = 10_000_000;
  localparam int FRC_OP_NS = 1000;
  localparam int FRC_OP_CYC = (FRC_OP_NS * (FRC_CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0]
  {
    FRC_MODE_CPU = 2'b00,
    FRC_MODE_SERIAL = 2'b01,
    FRC_MODE_PARALLEL = 2'b11
  } frc_mode_t;

  // five software commands
  typedef enum logic [2:0]
  {
    FRC_CMD_READ_ARRAY = 3'h1,
    FRC_CMD_READ_STATUS = 3'h2,
    FRC_CMD_CLEAR_STATUS = 3'h3,
    FRC_CMD_PROGRAM = 3'h4,
    FRC_CMD_BLOCK_ERASE = 3'h5
  } frc_cmd_t;

  typedef enum logic [1:0]
  {
    FRC_ST_IDLE = 2'b00,
    FRC_ST_BUSY = 2'b01,
    FRC_ST_DONE = 2'b11
  } frc_state_t;

  // request carried to the flash array
  typedef struct packed
  {
    logic valid;
    logic erase;
    logic bootArea;
    logic [2:0] block;
    logic [7:0] data;
  } frc_array_req_t;

  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } frc_apb_req_t;

endpackage

//--- sim/flash_rewrite_control_test.sv
`timescale 1ns/1ps
module flash_rewrite_control_test;
  import frc_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  frc_apb_req_t apbReq = '0;
  logic [1:0] modePins = 2'b00;
  logic idCheckPass = 0;
  logic romProtect = 0;
  logic slow = 0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, arrayBusy, fetchFromFlashOk, bootSelect, err, ga, b0, b1, ram;
  frc_array_req_t arrayReq;
  frc_array_req_t got[$];
  int failures = 0;
  int checked = 0;
  bit lockSeen = 1'b0;
  bit cmdSeen = 1'b0;
  always #50 ref_clk = ~ref_clk;
  frc_flash_rewrite_control i_dut
  (
    .ref_clk(ref_clk), .rst(rst), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modePins(modePins), .idCheckPass(idCheckPass), .romProtect(romProtect), .arrayReq(arrayReq),
    .arrayBusy(arrayBusy), .fetchFromFlashOk(fetchFromFlashOk), .bootSelect(bootSelect)
  );
  frc_array_model i_array
  (
    .ref_clk(ref_clk), .rst(rst), .arrayReq(arrayReq), .slow(slow), .arrayBusy(arrayBusy)
  );
  always @(posedge ref_clk)
    if (arrayReq.valid === 1'b1)
      got.push_back(arrayReq);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    apbReq <= '0;
  endtask
  function automatic bit allow(input logic [2:0] cmd, input int blk);
    if (!(cmd inside {3'h4, 3'h5}) || blk > 5)
      return 0;
    case (modePins)
      2'b00: return ga && (blk == 0 ? !b0 : blk == 1 ? !b1 : 1'b1);
      2'b01: return idCheckPass;
      2'b11: return !romProtect;
      default: return 0;
    endcase
  endfunction
  task automatic go(input logic [2:0] cmd, input int blk);
    logic [7:0] d;
    bit ok;
    int n;
    d = 8'($urandom);
    ok = allow(cmd, blk);
    slow <= 1'($urandom);
    got.delete();
    apb(1, FRC_CMD_OFS, {8'h00, d, 5'h00, 3'(blk), 5'h00, cmd});
    repeat (2) @(posedge ref_clk);
    #1 chk(got.size(), ok);
    if (got.size() == 1)
    begin
      chk({got[0].erase, got[0].block, cmd == 3'h4 ? got[0].data : d}, {cmd == 3'h5, 3'(blk), d});
      chk(got[0].bootArea, modePins == 2'b01);
    end
    chk(fetchFromFlashOk, !(ok && ram));
    if (cmd inside {3'h4, 3'h5} && !(modePins == 2'b01 && !idCheckPass))
      lockSeen = lockSeen | !ok;
    if (!(cmd inside {[3'h1:3'h5]}))
      cmdSeen = 1'b1;
    if (cmd == 3'h3)
    begin
      lockSeen = 1'b0;
      cmdSeen = 1'b0;
    end
    n = 0;
    do
    begin
      apb(0, FRC_STAT_OFS, '0);
      n++;
    end
    while (rd[3:2] !== 2'b00 && n < 80);
    chk(n < 80, 1);
    chk(rd[4], lockSeen);
    chk(rd[5], cmdSeen);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(96058));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    apb(0, FRC_CTRL_A_OFS, '0);
    chk(rd, 32'h0000_0000);
    apb(0, FRC_CTRL_B_OFS, '0);
    chk(rd, 32'h0000_0060);
    apb(0, 8'h10, '0);
    chk(err, 1);
    for (int k = 0; k < 16; k++)
    begin
      {ram, b1, b0, ga} = 4'(k);
      apb(1, FRC_CTRL_A_OFS, {29'h0, ga, ram, 1'b0});
      chk(err, 0);
      apb(1, FRC_CTRL_B_OFS, {25'h0, b1, b0, 5'h00});
      for (int b = 0; b < 8; b++)
        go(3'($urandom_range(5, 4)), b);
    end
    for (int c = 0; c < 4; c++)
      go(3'(c), 2);
    {ram, b1, b0, ga} = 4'h0;
    apb(1, FRC_CTRL_A_OFS, '0);
    // serial and parallel ignore the cpu lock bits
    for (int m = 0; m < 8; m++)
    begin
      modePins <= m[1:0];
      idCheckPass <= m[2];
      romProtect <= m[2];
      repeat (6) @(posedge ref_clk);
      #1 chk(bootSelect, m[1:0] == 2'b01);
      go(3'h4, m);
    end
    finish_test;
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    finish_test;
  end
endmodule

//--- sim/frc_array_model.sv
`timescale 1ns/1ps
module frc_array_model
  import frc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request side
  input wire frc_pkg::frc_array_req_t arrayReq,
  input wire logic slow,
  output logic arrayBusy
);
  int cnt;
  // slow array outlasts the sequencer's own minimum time
  always @(posedge ref_clk)
  begin
    if (rst)
      cnt <= 0;
    else if (arrayReq.valid === 1'b1)
      cnt <= slow ? 30 : 1;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign arrayBusy = cnt > 0;
endmodule

//--- sim/frc_flash_rewrite_control_chk.sv
`timescale 1ns/1ps
module frc_flash_rewrite_control_chk
  import frc_pkg::*;
#(parameter bit HAS_DATA_FLASH = 1'b1)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire frc_pkg::frc_apb_req_t apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and array
  input wire logic [1:0] modePins,
  input wire logic idCheckPass,
  input wire logic romProtect,
  input wire frc_pkg::frc_array_req_t arrayReq,
  input wire logic arrayBusy,
  input wire logic fetchFromFlashOk,
  input wire logic bootSelect
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pins pass two sync stages, so six steady cycles leave margin
  wire accessNow = apbReq.psel && apbReq.penable;
  wire mappedAddr = apbReq.paddr inside {FRC_CTRL_A_OFS, FRC_CTRL_B_OFS, FRC_CMD_OFS, FRC_STAT_OFS};
  wire cmdWrite = accessNow && apbReq.pwrite && apbReq.paddr == FRC_CMD_OFS && apbReq.pwdata[2:1] == 2'b10;
  ready_always_a: assert property (pready)
    else $error("pready low");
  err_unmapped_a: assert property (accessNow && !mappedAddr |-> pslverr)
    else $error("unmapped access not flagged");
  err_only_bad_a: assert property (pslverr |-> accessNow && !mappedAddr)
    else $error("spurious pslverr");
  launch_cause_a: assert property (arrayReq.valid |-> $past(cmdWrite) || $past(cmdWrite, 2))
    else $error("launch without command");
  launch_spacing_a: assert property (arrayReq.valid |=> !arrayReq.valid [*8])
    else $error("launch while busy");
  block_range_a: assert property (arrayReq.valid |-> arrayReq.block <= (HAS_DATA_FLASH ? 5 : 3))
    else $error("launch to missing block");
  serial_id_a: assert property ((modePins == 2'b01 && !idCheckPass) [*6] |-> !arrayReq.valid)
    else $error("serial launch without id");
  parallel_prot_a: assert property ((modePins == 2'b11 && romProtect) [*6] |-> !arrayReq.valid)
    else $error("launch while protected");
  no_mode_a: assert property ((modePins == 2'b10) [*6] |-> !arrayReq.valid)
    else $error("launch in undefined mode");
  boot_sel_a: assert property ((modePins == 2'b01) [*6] |-> bootSelect)
    else $error("boot area not selected");
  user_sel_a: assert property ((modePins != 2'b01) [*6] |-> !bootSelect)
    else $error("boot area selected outside serial mode");
  cover property (arrayReq.valid && arrayReq.erase);
  cover property (arrayReq.valid && bootSelect);
  cover property (accessNow && pslverr);
endmodule

bind frc_flash_rewrite_control frc_flash_rewrite_control_chk #(.HAS_DATA_FLASH(HAS_DATA_FLASH)) i_chk
(
  .ref_clk(ref_clk), .rst(rst), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .modePins(modePins), .idCheckPass(idCheckPass), .romProtect(romProtect), .arrayReq(arrayReq),
  .arrayBusy(arrayBusy), .fetchFromFlashOk(fetchFromFlashOk), .bootSelect(bootSelect)
);
